// *** core/lmsd_pkg.sv ***
// constants and types shared by the led matrix scan driver
//
// How it works
// - duty field picks 1/8, 1/9, 1/10 scan
// - prescaler divides fast rc clock 64..8
// - freeze bit stops the scan clock
// - main level for leds 0-31, 40-59
// - smoothing bit: uniform or enhanced brightness
// - odd level for leds 33-39 odd
// - even level for leds 32-38 even
// - odd level drives all direct-drive leds
// - pin-enable bit 7 selects direct drive
// - pin-enable bits 0-6 gate pins 2-8
package lmsd_pkg;
    // ----------------------------------------------------------------
    // register map (index times four is the byte address)
    // ----------------------------------------------------------------
    localparam int          PADDR_W          = 12;
    localparam logic [7:0]  IDX_SCAN_CTRL    = 8'hB1;
    localparam logic [7:0]  IDX_BRIGHT_CTRL  = 8'hB2;
    localparam logic [7:0]  IDX_PIN_ENABLE   = 8'hB3;
    localparam logic [PADDR_W-1:0] ADDR_SCAN_CTRL   = {2'h0, IDX_SCAN_CTRL, 2'h0};
    localparam logic [PADDR_W-1:0] ADDR_BRIGHT_CTRL = {2'h0, IDX_BRIGHT_CTRL, 2'h0};
    localparam logic [PADDR_W-1:0] ADDR_PIN_ENABLE  = {2'h0, IDX_PIN_ENABLE, 2'h0};
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_SCAN_CTRL    = 8'h07;
    localparam logic [7:0]  RST_BRIGHT_CTRL  = 8'h77;
    localparam logic [7:0]  RST_PIN_ENABLE   = 8'h00;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int          F_DUTY_LSB       = 6;
    localparam int          F_PSC_LSB        = 4;
    localparam int          F_FREEZE         = 3;
    localparam int          F_MAIN_LSB       = 0;
    localparam int          F_SMOOTH         = 7;
    localparam int          F_ODD_LSB        = 4;
    localparam int          F_EVEN_LSB       = 0;
    localparam int          F_DIRECT_EN      = 7;
    localparam int          DIRECT_PINS      = 7;
    // ----------------------------------------------------------------
    // scan geometry and prescaler
    // ----------------------------------------------------------------
    localparam logic [1:0]  DUTY_OFF         = 2'h0;
    localparam logic [1:0]  DUTY_8           = 2'h1;
    localparam logic [1:0]  DUTY_9           = 2'h2;
    localparam logic [3:0]  SLOTS_8          = 4'h8;
    localparam logic [3:0]  SLOTS_9          = 4'h9;
    localparam logic [3:0]  SLOTS_10         = 4'hA;
    localparam logic [2:0]  SEGS_4           = 3'h4;
    localparam logic [2:0]  SEGS_5           = 3'h5;
    localparam logic [2:0]  SEGS_6           = 3'h6;
    localparam int          MAX_SLOTS        = 10;
    localparam int          MAX_SEGS         = 6;
    localparam logic [6:0]  DIV_64           = 7'h40;
    localparam logic [6:0]  DIV_32           = 7'h20;
    localparam logic [6:0]  DIV_16           = 7'h10;
    localparam logic [6:0]  DIV_8            = 7'h08;
    localparam logic [2:0]  PHASE_LAST       = 3'h7;
    localparam logic [2:0]  LEVEL_MAX        = 3'h7;

    // operating mode of the driver
    typedef enum logic [2:0]
    {
        MODE_OFF    = 3'b001,
        MODE_MATRIX = 3'b010,
        MODE_DIRECT = 3'b100
    } lmsd_mode_e;
endpackage : lmsd_pkg

// *** core/lmsd_prescaler.sv ***
// scan clock divider from the fast internal rc clock
`timescale 1ns/1ps
`default_nettype none
module lmsd_prescaler
    import lmsd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] sel,
    input  wire logic       freeze,
    output var  logic       tick
);
    typedef struct packed
    {
        logic [6:0] cnt;
        logic       tick;
    } lmsd_psc_s;

    lmsd_psc_s st_r;
    lmsd_psc_s st_nxt;

    // divide ratio per prescaler code
    function automatic logic [6:0] div_of(input logic [1:0] code);
        unique case (code)
            2'h0:    div_of = DIV_64;
            2'h1:    div_of = DIV_32;
            2'h2:    div_of = DIV_16;
            default: div_of = DIV_8;
        endcase
    endfunction : div_of

    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (!freeze)
        begin
            if (st_r.cnt >= div_of(sel) - 7'h01)
            begin
                st_nxt.cnt  = 7'h00;
                st_nxt.tick = 1'b1;
            end
            else
            begin
                st_nxt.cnt = st_r.cnt + 7'h01;
            end
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tick = st_r.tick;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_tick_spacing: assert property (tick |=> !tick [*7])
        else $error("scan tick closer than eight cycles");
    a_freeze_quiet: assert property (freeze [*2] |=> !tick)
        else $error("scan tick while frozen");
endmodule : lmsd_prescaler
`default_nettype wire

// *** core/lmsd_dimmer.sv ***
// brightness gate: lit share of a slot from a three-bit level
`timescale 1ns/1ps
`default_nettype none
module lmsd_dimmer
    import lmsd_pkg::*;
(
    input  wire logic [2:0] level,
    input  wire logic [2:0] phase,
    input  wire logic       enhance,
    output var  logic       lit
);
    always_comb
    begin
        if (enhance && level != LEVEL_MAX)
            lit = (phase <= level + 3'h1);
        else
            lit = (phase <= level);
    end
endmodule : lmsd_dimmer
`default_nettype wire

// *** core/lmsd_top.sv ***
// led matrix scan driver: apb registers, scan sequencer, pin drive
`timescale 1ns/1ps
`default_nettype none
module lmsd_top
    import lmsd_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output var  logic               pready,
    output var  logic [31:0]        prdata,
    output var  logic               pslverr,
    input  wire logic [63:0]        led_data,
    output var  logic [MAX_SLOTS-1:0] com_drive,
    output var  logic [MAX_SEGS-1:0]  seg_drive,
    output var  logic [DIRECT_PINS-1:0] direct_drive,
    output var  logic [3:0]         scan_slot
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic [7:0]              scan_ctrl;
        logic [7:0]              bright_ctrl;
        logic [7:0]              pin_enable;
        logic                    pready;
        logic [31:0]             prdata;
        logic                    pslverr;
        lmsd_mode_e              mode;
        logic [2:0]              phase;
        logic [3:0]              slot;
        logic [MAX_SLOTS-1:0]    com;
        logic [MAX_SEGS-1:0]     seg;
        logic [DIRECT_PINS-1:0]  dpin;
    } lmsd_state_s;

    lmsd_state_s st_r;
    lmsd_state_s st_nxt;

    logic       scan_tick;
    logic       lit_main;
    logic       lit_odd;
    logic       lit_even;
    logic       wr_take;
    logic [1:0] duty;
    logic       smooth;

    assign duty    = st_r.scan_ctrl[F_DUTY_LSB +: 2];
    assign smooth  = st_r.bright_ctrl[F_SMOOTH];
    assign wr_take = psel && penable && pready && pwrite;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // slots per frame
    function automatic logic [3:0] slots_of(input logic [1:0] d);
        unique case (d)
            DUTY_8:  slots_of = SLOTS_8;
            DUTY_9:  slots_of = SLOTS_9;
            default: slots_of = SLOTS_10;
        endcase
    endfunction : slots_of

    function automatic logic [2:0] segs_of(input logic [1:0] d);
        unique case (d)
            DUTY_8:  segs_of = SEGS_4;
            DUTY_9:  segs_of = SEGS_5;
            default: segs_of = SEGS_6;
        endcase
    endfunction : segs_of

    // register hit for an address
    function automatic logic is_reg(input logic [PADDR_W-1:0] a);
        is_reg = (a == ADDR_SCAN_CTRL) || (a == ADDR_BRIGHT_CTRL)
              || (a == ADDR_PIN_ENABLE);
    endfunction : is_reg

    // ----------------------------------------------------------------
    // scan clock and brightness gates
    // ----------------------------------------------------------------
    lmsd_prescaler u_psc
    (
        .clk    (clk),
        .rst    (rst),
        .sel    (st_r.scan_ctrl[F_PSC_LSB +: 2]),
        .freeze (st_r.scan_ctrl[F_FREEZE]),
        .tick   (scan_tick)
    );

    lmsd_dimmer u_dim_main
    (
        .level   (st_r.scan_ctrl[F_MAIN_LSB +: 3]),
        .phase   (st_r.phase),
        .enhance (smooth),
        .lit     (lit_main)
    );

    lmsd_dimmer u_dim_odd
    (
        .level   (st_r.bright_ctrl[F_ODD_LSB +: 3]),
        .phase   (st_r.phase),
        .enhance (smooth),
        .lit     (lit_odd)
    );

    lmsd_dimmer u_dim_even
    (
        .level   (st_r.bright_ctrl[F_EVEN_LSB +: 3]),
        .phase   (st_r.phase),
        .enhance (smooth),
        .lit     (lit_even)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [5:0] led_no;
        led_no = 6'h00;
        st_nxt = st_r;

        // apb answer is ready in the access cycle after setup
        st_nxt.pready  = psel && !penable;
        st_nxt.pslverr = psel && !penable && !is_reg(paddr);
        if (psel && !penable)
        begin
            unique case (paddr)
                ADDR_SCAN_CTRL:   st_nxt.prdata = {24'h0, st_r.scan_ctrl};
                ADDR_BRIGHT_CTRL: st_nxt.prdata = {24'h0, st_r.bright_ctrl};
                ADDR_PIN_ENABLE:  st_nxt.prdata = {24'h0, st_r.pin_enable};
                default:          st_nxt.prdata = 32'h0;
            endcase
        end

        // register writes at the access edge
        if (wr_take && paddr == ADDR_SCAN_CTRL)
            st_nxt.scan_ctrl = pwdata[7:0];
        if (wr_take && paddr == ADDR_BRIGHT_CTRL)
            st_nxt.bright_ctrl = pwdata[7:0];
        if (wr_take && paddr == ADDR_PIN_ENABLE)
            st_nxt.pin_enable = pwdata[7:0];

        if (st_r.pin_enable[F_DIRECT_EN])
            st_nxt.mode = MODE_DIRECT;
        else if (duty != DUTY_OFF)
            st_nxt.mode = MODE_MATRIX;
        else
            st_nxt.mode = MODE_OFF;

        // sequence moves on scan ticks; a matrix slot beyond the duty count clears to 0 without one
        if (scan_tick)
        begin
            st_nxt.phase = st_r.phase + 3'h1;
            if (st_r.phase == PHASE_LAST)
            begin
                if (st_r.slot >= slots_of(duty) - 4'h1)
                    st_nxt.slot = 4'h0;
                else
                    st_nxt.slot = st_r.slot + 4'h1;
            end
        end
        if (st_r.mode == MODE_MATRIX && st_r.slot >= slots_of(duty))
            st_nxt.slot = 4'h0;

        // pin drive
        st_nxt.com  = '0;
        st_nxt.seg  = '0;
        st_nxt.dpin = '0;
        unique case (st_r.mode)
            MODE_MATRIX:
            begin
                st_nxt.com[st_r.slot] = 1'b1;
                for (int j = 0; j < MAX_SEGS; j++)
                begin
                    led_no = 6'(st_r.slot * 6 + j);
                    if (3'(j) < segs_of(duty) && led_data[led_no])
                    begin
                        if (led_no >= 6'd32 && led_no <= 6'd39 && led_no[0])
                            st_nxt.seg[j] = lit_odd;
                        else if (led_no >= 6'd32 && led_no <= 6'd39)
                            st_nxt.seg[j] = lit_even;
                        else
                            st_nxt.seg[j] = lit_main;
                    end
                end
            end
            MODE_DIRECT:
            begin
                st_nxt.dpin = st_r.pin_enable[DIRECT_PINS-1:0]
                            & led_data[DIRECT_PINS-1:0]
                            & {DIRECT_PINS{lit_odd}};
            end
            MODE_OFF:
            begin
                st_nxt.dpin = '0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r             <= '0;
            st_r.scan_ctrl   <= RST_SCAN_CTRL;
            st_r.bright_ctrl <= RST_BRIGHT_CTRL;
            st_r.pin_enable  <= RST_PIN_ENABLE;
            st_r.mode        <= MODE_OFF;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    assign pready       = st_r.pready;
    assign prdata       = st_r.prdata;
    assign pslverr      = st_r.pslverr;
    assign com_drive    = st_r.com;
    assign seg_drive    = st_r.seg;
    assign direct_drive = st_r.dpin;
    assign scan_slot    = st_r.slot;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_setup;
        psel && !penable;
    endsequence

    a_ready_after_setup: assert property (s_setup |=> pready && !$past(pready))
        else $error("apb answer not one cycle after setup");
    a_unmapped_error: assert property ((s_setup and !is_reg(paddr)) |=> pslverr)
        else $error("unmapped access without error");
    a_ctrl_write: assert property (wr_take && paddr == ADDR_SCAN_CTRL
        |=> duty == $past(pwdata[7:6]))
        else $error("duty field not written");
    a_slot_bound: assert property (st_r.mode == MODE_MATRIX && $stable(duty)
        |=> st_r.slot < slots_of(duty))
        else $error("slot beyond duty count");
    a_freeze_hold: assert property (st_r.scan_ctrl[F_FREEZE] [*3]
        |=> $stable(st_r.phase))
        else $error("scan moved while frozen");
    a_direct_gated: assert property (st_r.mode == MODE_DIRECT
        |=> (st_r.dpin & ~$past(st_r.pin_enable[6:0])) == 7'h00)
        else $error("disabled direct pin driven");
    a_direct_select: assert property (st_r.pin_enable[F_DIRECT_EN]
        |=> st_r.mode == MODE_DIRECT)
        else $error("direct mode not entered");
    a_off_dark: assert property (st_r.mode == MODE_OFF
        |=> st_r.com == '0 && st_r.dpin == '0)
        else $error("pins driven with driver off");
    a_level_zero: assert property (st_r.mode == MODE_DIRECT && !smooth
        && st_r.bright_ctrl[6:4] == 3'h0 && st_r.phase != 3'h0
        |=> st_r.dpin == '0)
        else $error("level zero lit beyond first sub-slot");
endmodule : lmsd_top
`default_nettype wire

// *** testbench/lmsd_led_array.sv ***
// led array model hanging on the common, segment and direct pins
`timescale 1ns/1ps
`default_nettype none
module lmsd_led_array
    import lmsd_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic [63:0]            pattern,
    input  wire logic [MAX_SLOTS-1:0]   com_drive,
    input  wire logic [MAX_SEGS-1:0]    seg_drive,
    input  wire logic [DIRECT_PINS-1:0] direct_drive,
    output var  logic [63:0]            led_data
);
    int lit_cnt [64] = '{default: 0};
    int pin_cnt [DIRECT_PINS] = '{default: 0};

    // leds show the wanted on pattern
    assign led_data = pattern;

    // ------------------------------------------------------------
    // light meter
    // ------------------------------------------------------------
    // lit time per matrix led
    // counted on the falling edge, where the drives have settled
    always @(negedge clk)
    begin
        for (int k = 0; k < MAX_SLOTS; k++)
            for (int j = 0; j < MAX_SEGS; j++)
                if (com_drive[k] && seg_drive[j])
                    lit_cnt[k*MAX_SEGS+j] += 1;
        for (int p = 0; p < DIRECT_PINS; p++)
            if (direct_drive[p])
                pin_cnt[p] += 1;
    end
endmodule : lmsd_led_array
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the led matrix scan driver
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import lmsd_pkg::*;
;
    logic                   clk;
    logic                   rst;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [PADDR_W-1:0]     paddr;
    logic [31:0]            pwdata;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [63:0]            pattern;
    logic [63:0]            led_data;
    logic [MAX_SLOTS-1:0]   com_drive;
    logic [MAX_SEGS-1:0]    seg_drive;
    logic [DIRECT_PINS-1:0] direct_drive;
    logic [3:0]             scan_slot;
    logic [31:0]            rd;
    logic                   er;
    int                     mismatches;
    int                     tests_run;

    typedef struct {logic [7:0] scan; logic [7:0] bright; int div; int slots;} lmsd_row_s;
    // scan ctrl, brightness ctrl, clock divide, slots per frame
    lmsd_row_s rows [4] = '{
        '{8'h40, 8'h53, 64, 8},
        '{8'h96, 8'hA1, 32, 9},
        '{8'hE3, 8'h07, 16, 10},
        '{8'hF7, 8'hF0, 8, 10}};

    lmsd_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .led_data(led_data), .com_drive(com_drive),
        .seg_drive(seg_drive), .direct_drive(direct_drive), .scan_slot(scan_slot));

    lmsd_led_array u_leds (.clk(clk), .pattern(pattern), .com_drive(com_drive),
        .seg_drive(seg_drive), .direct_drive(direct_drive), .led_data(led_data));

    // ------------------------------------------------------------
    // clock and helpers
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    task automatic give_verdict;
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic stall;
        mismatches++;
        $display("MISMATCH at %0t: wait ran out, got %h expected %h", $time, 1'h0, 1'h1);
        give_verdict();
    endtask : stall

    // one apb transfer, called just after a rising edge
    task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [7:0] d);
        int n;
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'h1 && n < 16);
        if (n >= 16)
            stall();
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask : apb

    // cycles until the scan slot moves on
    task automatic wait_change(output int p);
        logic [3:0] s;
        s = scan_slot;
        p = 0;
        do
        begin
            @(posedge clk);
            p++;
        end
        while (scan_slot === s && p < 6000);
        if (p >= 6000)
            stall();
    endtask : wait_change

    // lit clocks per slot for a level
    function automatic int exp_lit(input logic [2:0] lv, input logic sm, input int div);
        int e;
        e = lv + 1;
        if (sm && lv != 3'h7)
            e = e + 1;
        return e * div;
    endfunction : exp_lit

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        int p;
        int cnt;
        int per;
        int b0;
        int b32;
        int b33;
        logic [31:0] orc;
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = '0;
        pwdata = '0;
        pattern = {64{1'h1}};
        mismatches = 0;
        tests_run = 0;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        // table rows: mode, divide, wrap and brightness per group
        for (int i = 0; i < 4; i++)
        begin
            apb(1'h1, ADDR_SCAN_CTRL, rows[i].scan);
            apb(1'h1, ADDR_BRIGHT_CTRL, rows[i].bright);
            apb(1'h0, ADDR_BRIGHT_CTRL, 8'h00);
            chk(rd, {24'h000000, rows[i].bright});
            cnt = 0;
            do
            begin
                wait_change(p);
                cnt++;
            end
            while (scan_slot !== 4'h0 && cnt < 12);
            b0 = u_leds.lit_cnt[0];
            b32 = u_leds.lit_cnt[32];
            b33 = u_leds.lit_cnt[33];
            cnt = 0;
            do
            begin
                wait_change(p);
                if (cnt == 0)
                    per = p;
                cnt++;
            end
            while (scan_slot !== 4'h0 && cnt < 12);
            chk(cnt, rows[i].slots);
            chk(per, 8 * rows[i].div);
            chk(u_leds.lit_cnt[0] - b0,
                exp_lit(rows[i].scan[2:0], rows[i].bright[7], rows[i].div));
            chk(u_leds.lit_cnt[32] - b32,
                exp_lit(rows[i].bright[2:0], rows[i].bright[7], rows[i].div));
            chk(u_leds.lit_cnt[33] - b33,
                exp_lit(rows[i].bright[6:4], rows[i].bright[7], rows[i].div));
            repeat (2) @(posedge clk);
            chk(com_drive, 32'h1);
            $display("row %0d done", i);
        end
        // freeze holds the scan, release lets it run again
        apb(1'h1, ADDR_SCAN_CTRL, 8'hFF);
        // a tick already in flight may still move the slot once
        repeat (2) @(posedge clk);
        b0 = scan_slot;
        repeat (200) @(posedge clk);
        chk(scan_slot, b0);
        apb(1'h1, ADDR_SCAN_CTRL, 8'hF7);
        wait_change(p);
        // eight ticks of eight clocks plus one register stage
        chk(p <= 65, 1'h1);
        $display("freeze test done");
        // direct drive: pin mapping, priority, shared level
        apb(1'h1, ADDR_BRIGHT_CTRL, 8'h70);
        apb(1'h1, ADDR_PIN_ENABLE, 8'hD5);
        pattern <= 64'h3C;
        repeat (4) @(posedge clk);
        chk(direct_drive, 32'h14);
        chk(com_drive, 32'h0);
        apb(1'h1, ADDR_BRIGHT_CTRL, 8'h00);
        pattern <= {64{1'h1}};
        apb(1'h1, ADDR_PIN_ENABLE, 8'hFF);
        b0 = u_leds.pin_cnt[6];
        repeat (640) @(posedge clk);
        chk(u_leds.pin_cnt[6] - b0, 80);
        apb(1'h1, ADDR_PIN_ENABLE, 8'h7F);
        repeat (4) @(posedge clk);
        orc = '0;
        repeat (100) @(posedge clk) orc |= direct_drive;
        chk(orc, 32'h0);
        $display("direct test done");
        // duty off keeps commons and segments dark
        apb(1'h1, ADDR_SCAN_CTRL, 8'h37);
        repeat (4) @(posedge clk);
        orc = '0;
        repeat (200) @(posedge clk) orc |= {seg_drive, com_drive};
        chk(orc, 32'h0);
        // unmapped place refuses and reads zero
        apb(1'h1, 12'h2D0, 8'hFF);
        chk(er, 1'h1);
        apb(1'h0, 12'h2D0, 8'h00);
        chk(rd, 32'h0);
        $display("off and unmapped test done");
        // reset in mid-run restores defaults
        apb(1'h1, ADDR_SCAN_CTRL, 8'hF7);
        repeat (30) @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        chk(com_drive, 32'h0);
        apb(1'h0, ADDR_SCAN_CTRL, 8'h00);
        chk(rd, 32'h07);
        apb(1'h0, ADDR_BRIGHT_CTRL, 8'h00);
        chk(rd, 32'h77);
        apb(1'h0, ADDR_PIN_ENABLE, 8'h00);
        chk(rd, 32'h00);
        $display("reset test done");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
